// *** include/clk_rst_pkg.sv ***
// constants, types and field layout for the clock switch and reset controller
package clk_rst_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_SYS_CTRL = 8'h00; // system_control_two
   localparam logic [7:0] OFF_TRAP_CTRL = 8'h04; // watchdog_control_one
   localparam logic [7:0] OFF_IRQ_EN = 8'h08;
   localparam logic [7:0] OFF_IRQ_LATCH = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   // system_control_two fields
   localparam int BIT_CLK_SEL = 5;
   localparam int BIT_LO_EN = 6;
   localparam int BIT_HI_EN = 7;
   // watchdog_control_one fields
   localparam int BIT_TRAP_RAM = 0; // trap_ram_area_bit
   localparam int BIT_TRAP_RST = 1; // 1: trap resets, 0: trap interrupts
   localparam int BIT_WDT_EN = 2;
   // reset values
   localparam logic [7:0] SYS_CTRL_RST = 8'h80;
   localparam logic [7:0] TRAP_CTRL_RST = 8'h06;
   localparam logic [15:0] IRQ_RST = 16'h0000;
   // interrupt latch used by the address trap
   localparam int IRQ_TRAP_BIT = 2;
   // timing: one ref_clk period stands for one high_clock_freq period
   localparam int CLK_PERIOD_NS = 50;
   localparam int PIN_LOW_MIN_NS = 12 * CLK_PERIOD_NS;
   localparam int PIN_LOW_CYC = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_RST_MAX_NS = 24 * CLK_PERIOD_NS;
   localparam int INT_RST_CYC = INT_RST_MAX_NS / CLK_PERIOD_NS;
   // prescaler ratio giving the low clock enable
   localparam int LO_DIV = 8;
   // fetch address regions
   localparam logic [15:0] SPECIAL_FUNCTION_AREA_LO = 16'h0000;
   localparam logic [15:0] SPECIAL_FUNCTION_AREA_HI = 16'h003f;
   localparam logic [15:0] RAM_LO = 16'h0040;
   localparam logic [15:0] RAM_HI = 16'h083f;
   localparam logic [15:0] DATA_BUFFER_REGION_LO = 16'h0f00;
   localparam logic [15:0] DATA_BUFFER_REGION_HI = 16'h0fff;
   localparam logic [15:0] RESET_VECTOR = 16'hfffe;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      SINGLE_CLOCK_FAST_MODE = 2'b00,
      DUAL_CLOCK_FAST_MODE = 2'b01,
      LOW_CLOCK_DUAL_OSC_MODE = 2'b10,
      LOW_CLOCK_ONLY_MODE = 2'b11
   } mode_t;
   typedef struct packed {
      logic hi_en;
      logic lo_en;
      logic clk_sel;
   } clk_ctrl_t;
   typedef struct packed {
      logic pin;
      logic trap;
      logic wdt;
      logic clk_loss;
   } cause_t;
endpackage

// *** rtl/clock_switch_and_reset_ctrl.sv ***
// clock source switching and chip reset generation with an axi4-lite register port
// Functional notes
// - writing clock select 1 moves the system clock to the low oscillator
// - clearing the high oscillator enable stops the high oscillator
// - setting the low oscillator enable starts the low oscillator
// - after select cleared, keep low clock until clocks align, then change
// - reset pin low in slow mode resets; comes up in single clock fast mode
// - internal reset requests hold the chip in reset at most 24 clock periods
// - internal resets never drive the external reset pin low
// - reset pin low for twelve clock periods is recognised as reset
// - on release, fetch the vector at the top two bytes and start there
// - reset clears master enable, enable flags and interrupt latches
// - reset clears prescaler and divider and leaves watchdog enabled
// - fetch from special, buffer or trapped ram area raises address trap reset
// - address trap response selectable between reset and interrupt
// - disabling the selected or both oscillators raises a clock loss reset
`timescale 1ns/1ps
`default_nettype none
module clock_switch_and_reset_ctrl
   import clk_rst_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external reset pin (input with pull-up)
   input wire logic reset_pin_in,
   output logic reset_pin_out,
   output logic reset_pin_oe,
   // cpu side
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic wdt_expire,
   input wire logic [15:0] irq_req,
   output logic irq_pending,
   output logic chip_reset_n,
   output logic vector_fetch,
   output logic [15:0] vector_addr,
   // oscillator and clock control
   output logic hi_osc_run,
   output logic lo_osc_run,
   output logic run_on_lo,
   output logic lo_tick,
   output logic wdt_enable,
   output mode_t mode
);
   // byte-lane merge for a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] strb);
      merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
   endfunction
   // true when the offset names a register
   function automatic logic mapped(input logic [7:0] a);
      if (a == OFF_SYS_CTRL) mapped = 1'b1;
      else if (a == OFF_TRAP_CTRL) mapped = 1'b1;
      else if (a == OFF_IRQ_EN) mapped = 1'b1;
      else if (a == OFF_IRQ_LATCH) mapped = 1'b1;
      else if (a == OFF_STATUS) mapped = 1'b1;
      else mapped = 1'b0;
   endfunction
   // clock loss check on a proposed control value
   function automatic logic clk_loss(input clk_ctrl_t c);
      clk_loss = (!c.hi_en && !c.lo_en) || (!c.hi_en && !c.clk_sel) ||
                 (!c.lo_en && c.clk_sel);
   endfunction
   logic pin_s1_r, pin_s2_r, pin_rst_r, pin_rst_nxt, sys_rst, sys_rst_d_r, vec_r;
   logic [4:0] pin_cnt_r, pin_cnt_nxt, int_cnt_r, int_cnt_nxt, low_run_r, low_run_nxt;
   logic trap_hit, trap_rst_req, loss_req, int_req, wr_fire;
   cause_t cause_r, cause_nxt;
   clk_ctrl_t ctrl_r, ctrl_nxt, ctrl_wr;
   logic [2:0] trap_ctrl_r, trap_ctrl_nxt, presc_r, presc_nxt;
   logic [15:0] irq_en_r, irq_en_nxt, irq_lat_r, irq_lat_nxt, irq_set;
   logic run_lo_r, run_lo_nxt, aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [7:0] aw_addr_r, aw_addr_nxt, wa;
   logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt, wd;
   logic [3:0] w_strb_r, w_strb_nxt, ws;
   logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   // two-stage pin synchroniser; only the second stage feeds logic
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
      end else begin
         pin_s1_r <= reset_pin_in;
         pin_s2_r <= pin_s1_r;
      end
   end
   // pin filter: glitches shorter than the minimum low time are ignored
   always_comb begin
      pin_cnt_nxt = pin_cnt_r;
      low_run_nxt = pin_s2_r ? 5'h00 : (low_run_r == 5'h1f) ? low_run_r : low_run_r + 5'h01;
      pin_rst_nxt = pin_rst_r;
      if (pin_s2_r) begin
         pin_cnt_nxt = 5'h00;
         pin_rst_nxt = 1'b0;
      end else if (pin_cnt_r == 5'(PIN_LOW_CYC - 1)) begin
         pin_rst_nxt = 1'b1;
      end else begin
         pin_cnt_nxt = pin_cnt_r + 5'h01;
      end
   end
   // pin drive stays off: internal resets are not seen at the pin
   assign reset_pin_out = 1'b0;
   assign reset_pin_oe = 1'b0;
   // one merged synchronous reset for the control, interrupt, prescaler and clock-run state; the other registers use the plain bus reset
   assign sys_rst = !reset_n || pin_rst_r || (int_cnt_r != 5'h00);
   assign chip_reset_n = !sys_rst;
   // address trap detect, ignored while already in reset
   assign trap_hit = fetch_valid && !sys_rst &&
      ((fetch_addr >= SPECIAL_FUNCTION_AREA_LO && fetch_addr <= SPECIAL_FUNCTION_AREA_HI) ||
       (fetch_addr >= DATA_BUFFER_REGION_LO && fetch_addr <= DATA_BUFFER_REGION_HI) ||
       (trap_ctrl_r[BIT_TRAP_RAM] && fetch_addr >= RAM_LO && fetch_addr <= RAM_HI));
   assign trap_rst_req = trap_hit && trap_ctrl_r[BIT_TRAP_RST];
   // axi write combine: address and data may arrive in either order
   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready = !w_hold_r && !bvalid_r;
   assign wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
   assign wd = w_hold_r ? w_data_r : s_axi_wdata;
   assign ws = w_hold_r ? w_strb_r : s_axi_wstrb;
   assign wr_fire = !bvalid_r && (aw_hold_r || s_axi_awvalid) && (w_hold_r || s_axi_wvalid);
   assign ctrl_wr = ws[0] ? {wd[BIT_HI_EN], wd[BIT_LO_EN], wd[BIT_CLK_SEL]} : ctrl_r;
   assign loss_req = wr_fire && !sys_rst && wa == OFF_SYS_CTRL && clk_loss(ctrl_wr);
   assign int_req = trap_rst_req || loss_req || (wdt_expire && !sys_rst);
   // internal reset timer and cause capture
   always_comb begin
      int_cnt_nxt = int_cnt_r;
      cause_nxt = cause_r;
      if (int_cnt_r != 5'h00) begin
         int_cnt_nxt = int_cnt_r - 5'h01;
      end else if (int_req) begin
         int_cnt_nxt = 5'(INT_RST_CYC);
         cause_nxt = '{pin: 1'b0, trap: trap_rst_req, wdt: wdt_expire, clk_loss: loss_req};
      end
      if (pin_rst_r) begin
         cause_nxt = '{pin: 1'b1, trap: 1'b0, wdt: 1'b0, clk_loss: 1'b0};
      end
   end
   // control, interrupt and prescaler state under the merged reset
   always_comb begin
      ctrl_nxt = ctrl_r;
      trap_ctrl_nxt = trap_ctrl_r;
      irq_en_nxt = irq_en_r;
      irq_set = irq_req;
      if (trap_hit && !trap_ctrl_r[BIT_TRAP_RST]) begin
         irq_set[IRQ_TRAP_BIT] = 1'b1;
      end
      irq_lat_nxt = irq_lat_r;
      if (wr_fire && wa == OFF_SYS_CTRL && !loss_req) begin
         ctrl_nxt = ctrl_wr;
      end
      if (wr_fire && wa == OFF_TRAP_CTRL && ws[0]) begin
         trap_ctrl_nxt = wd[2:0];
      end
      if (wr_fire && wa == OFF_IRQ_EN) begin
         irq_en_nxt = merge16(irq_en_r, wd, ws);
      end
      if (wr_fire && wa == OFF_IRQ_LATCH) begin
         irq_lat_nxt = merge16(irq_lat_r, wd, ws) & irq_lat_r; // writing 0 clears
      end
      irq_lat_nxt = irq_lat_nxt | irq_set; // a new request beats a clear
      presc_nxt = (presc_r == 3'(LO_DIV - 1)) ? 3'h0 : presc_r + 3'h1;
      // hold the low clock until the next aligned low tick before going fast
      run_lo_nxt = run_lo_r;
      if (ctrl_r.clk_sel) begin
         run_lo_nxt = 1'b1;
      end else if (lo_tick) begin
         run_lo_nxt = 1'b0;
      end
      if (sys_rst) begin
         ctrl_nxt = {SYS_CTRL_RST[BIT_HI_EN], SYS_CTRL_RST[BIT_LO_EN],
                     SYS_CTRL_RST[BIT_CLK_SEL]};
         trap_ctrl_nxt = TRAP_CTRL_RST[2:0];
         irq_en_nxt = IRQ_RST;
         irq_lat_nxt = IRQ_RST;
         presc_nxt = 3'h0;
         run_lo_nxt = 1'b0;
      end
   end

   assign lo_tick = (presc_r == 3'(LO_DIV - 1));
   assign hi_osc_run = ctrl_r.hi_en;
   assign lo_osc_run = ctrl_r.lo_en;
   assign run_on_lo = run_lo_r;
   assign wdt_enable = trap_ctrl_r[BIT_WDT_EN];
   assign irq_pending = irq_en_r[0] && |(irq_en_r[15:1] & irq_lat_r[15:1]);
   assign vector_fetch = vec_r;
   assign vector_addr = RESET_VECTOR;
   // operating mode from the clock in use and the enable of the other oscillator
   always_comb begin
      if (!run_lo_r) mode = ctrl_r.lo_en ? DUAL_CLOCK_FAST_MODE : SINGLE_CLOCK_FAST_MODE;
      else mode = ctrl_r.hi_en ? LOW_CLOCK_DUAL_OSC_MODE : LOW_CLOCK_ONLY_MODE;
   end
   // axi channel bookkeeping
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_hold_nxt = w_hold_r;
      w_data_nxt = w_data_r;
      w_strb_nxt = w_strb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt = rresp_r;
      rdata_nxt = rdata_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         rdata_nxt = 32'h0000_0000;
         if (s_axi_araddr == OFF_SYS_CTRL) begin
            rdata_nxt[BIT_HI_EN] = ctrl_r.hi_en;
            rdata_nxt[BIT_LO_EN] = ctrl_r.lo_en;
            rdata_nxt[BIT_CLK_SEL] = ctrl_r.clk_sel;
         end else if (s_axi_araddr == OFF_TRAP_CTRL) begin
            rdata_nxt[2:0] = trap_ctrl_r;
         end else if (s_axi_araddr == OFF_IRQ_EN) begin
            rdata_nxt[15:0] = irq_en_r;
         end else if (s_axi_araddr == OFF_IRQ_LATCH) begin
            rdata_nxt[15:0] = irq_lat_r;
         end else if (s_axi_araddr == OFF_STATUS) begin
            rdata_nxt[7:0] = {cause_r, 1'b0, run_lo_r, mode};
         end
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   // registers on the plain bus reset
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pin_cnt_r <= 5'h00;
         low_run_r <= 5'h00;
         pin_rst_r <= 1'b0;
         int_cnt_r <= 5'h00;
         cause_r <= '0;
         sys_rst_d_r <= 1'b1;
         vec_r <= 1'b0;
         aw_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_hold_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else begin
         pin_cnt_r <= pin_cnt_nxt;
         low_run_r <= low_run_nxt;
         pin_rst_r <= pin_rst_nxt;
         int_cnt_r <= int_cnt_nxt;
         cause_r <= cause_nxt;
         sys_rst_d_r <= sys_rst;
         vec_r <= sys_rst_d_r && !sys_rst;
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r <= w_hold_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r <= rresp_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // state cleared by the merged reset inside the next-value logic
   always_ff @(posedge ref_clk) begin
      ctrl_r <= ctrl_nxt;
      trap_ctrl_r <= trap_ctrl_nxt;
      irq_en_r <= irq_en_nxt;
      irq_lat_r <= irq_lat_nxt;
      presc_r <= presc_nxt;
      run_lo_r <= run_lo_nxt;
   end

   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   int_rst_len_a: assert property ($rose(int_cnt_r != 5'h00) |->
      (int_cnt_r != 5'h00)[*8] ##16 (int_cnt_r == 5'h01) ##1 (int_cnt_r == 5'h00))
      else $error("internal reset length wrong");
   pin_filter_a: assert property (!pin_s2_r && low_run_r >= 5'(PIN_LOW_CYC) |->
      pin_rst_r) else $error("pin low not recognised");
   pin_release_a: assert property (pin_s2_r |=> !pin_rst_r)
      else $error("pin reset not released");
   pin_quiet_a: assert property (reset_pin_oe == 1'b0)
      else $error("reset pin driven");
   loss_reset_a: assert property (loss_req && int_cnt_r == 5'h00 |=>
      (int_cnt_r == 5'(INT_RST_CYC)) && !chip_reset_n)
      else $error("clock loss did not reset");
   slow_entry_a: assert property (!sys_rst && ctrl_r.clk_sel |=> run_lo_r)
      else $error("low clock not selected");
   fast_return_a: assert property (run_lo_r && !ctrl_r.clk_sel && !lo_tick && !sys_rst
      |=> run_lo_r)
      else $error("left low clock before alignment");
   reset_init_a: assert property (sys_rst |=> irq_en_r == IRQ_RST && irq_lat_r == IRQ_RST &&
      presc_r == 3'h0 && wdt_enable && mode == SINGLE_CLOCK_FAST_MODE)
      else $error("reset state not initialised");
   trap_reset_a: assert property (trap_rst_req && int_cnt_r == 5'h00 |=> !chip_reset_n)
      else $error("address trap did not reset");
   trap_irq_a: assert property (trap_hit && !trap_ctrl_r[BIT_TRAP_RST] |=>
      irq_lat_r[IRQ_TRAP_BIT] && chip_reset_n)
      else $error("address trap interrupt missing");
   osc_follow_a: assert property (wr_fire && wa == OFF_SYS_CTRL && !loss_req && !sys_rst
      |=> ctrl_r == $past(ctrl_wr))
      else $error("oscillator enables not written");
   reset_vector_a: assert property ($fell(sys_rst) |=> vector_fetch)
      else $error("vector fetch missing");
   slow_cov_c: cover property (ctrl_r.clk_sel ##1 run_lo_r ##[1:20] !run_lo_r);
   loss_cov_c: cover property (loss_req);
   pin_cov_c: cover property ($rose(pin_rst_r));
   trap_cov_c: cover property (trap_hit && !trap_ctrl_r[BIT_TRAP_RST]);
endmodule
`default_nettype wire

// *** verification/cpu_pin_model.sv ***
// stand-in for the cpu core and the external reset pin driver
`timescale 1ns/1ps
`default_nettype none
module cpu_pin_model (
   // clock
   input wire logic ref_clk,
   // reset pin as driven by the device
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_level,
   // cpu requests
   output logic fetch_valid,
   output logic [15:0] fetch_addr,
   output logic wdt_expire,
   output logic [15:0] irq_req
);
   logic pull_low = 1'b0;
   // pull-up keeps the wire high unless someone pulls it down
   assign pin_level = pin_oe ? pin_out : !pull_low;
   // idle values at time zero
   initial begin
      fetch_valid = 1'b0;
      fetch_addr = 16'h8000;
      wdt_expire = 1'b0;
      irq_req = 16'h0000;
   end
   // hold the pin low for n cycles, then let the pull-up win
   task automatic pin_low(input int n);
      @(posedge ref_clk);
      pull_low <= 1'b1;
      repeat (n) @(posedge ref_clk);
      pull_low <= 1'b0;
   endtask
   // one fetch cycle; the address is scrambled outside it
   task automatic fetch(input logic [15:0] a);
      @(posedge ref_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      @(posedge ref_clk);
      fetch_valid <= 1'b0;
      fetch_addr <= ~a;
   endtask
   // one-cycle watchdog expiry and interrupt requests
   task automatic request(input logic w, input logic [15:0] m);
      @(posedge ref_clk);
      wdt_expire <= w;
      irq_req <= m;
      @(posedge ref_clk);
      wdt_expire <= 1'b0;
      irq_req <= 16'h0000;
   endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking bench for the clock switch and reset controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   checked++; \
   if ((got) !== (exp)) begin \
      num_errors++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
   end \
end
module tb;
   import clk_rst_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic reset_pin_in, reset_pin_out, reset_pin_oe, fetch_valid, wdt_expire;
   logic irq_pending, chip_reset_n, vector_fetch;
   logic [15:0] fetch_addr, irq_req, vector_addr;
   logic hi_osc_run, lo_osc_run, run_on_lo, lo_tick, wdt_enable;
   mode_t mode;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int len;
   clock_switch_and_reset_ctrl dut (.ref_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reset_pin_in, .reset_pin_out,
      .reset_pin_oe, .fetch_valid, .fetch_addr, .wdt_expire, .irq_req, .irq_pending,
      .chip_reset_n, .vector_fetch, .vector_addr, .hi_osc_run, .lo_osc_run, .run_on_lo,
      .lo_tick, .wdt_enable, .mode);
   cpu_pin_model cpu (.ref_clk, .pin_out(reset_pin_out), .pin_oe(reset_pin_oe),
      .pin_level(reset_pin_in), .fetch_valid, .fetch_addr, .wdt_expire, .irq_req);
   // clock and hang guard; whole run is a few hundred cycles
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // handshakes are sampled at the falling edge, where everything has settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, b;
      logic [1:0] r;
      r = 2'b11;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge ref_clk);
         aw = s_axi_awvalid && s_axi_awready;
         w = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge ref_clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) begin
            s_axi_bready <= 1'b0;
            break;
         end
      end
      `CHK(r, er)
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
         input logic [1:0] er);
      logic ar, done;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 100; n++) begin
         @(negedge ref_clk);
         ar = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge ref_clk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (done) begin
            s_axi_rready <= 1'b0;
            break;
         end
      end
      `CHK(d & m, e)
      `CHK(r, er)
   endtask
   // length of the next chip reset, zero if none within 40 cycles
   task automatic rst_len(output int l);
      int n;
      n = 0;
      l = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (chip_reset_n !== 1'b0 && n < 40);
      while (chip_reset_n === 1'b0 && l < 100) begin
         l++;
         `CHK(reset_pin_oe, 1'b0)
         `CHK(reset_pin_out, 1'b0)
         @(negedge ref_clk);
      end
      if (l > 0) begin
         @(negedge ref_clk);
         `CHK(vector_fetch, 1'b1)
         `CHK(vector_addr, RESET_VECTOR)
      end
   endtask
   task automatic s_reset_values();
      rdc(OFF_SYS_CTRL, 32'hff, SYS_CTRL_RST, RESP_OKAY);
      rdc(OFF_TRAP_CTRL, 32'hff, TRAP_CTRL_RST, RESP_OKAY);
      rdc(OFF_IRQ_EN, 32'hffff, IRQ_RST, RESP_OKAY);
      rdc(OFF_IRQ_LATCH, 32'hffff, IRQ_RST, RESP_OKAY);
      rdc(8'h14, 32'hffffffff, 32'h0, RESP_SLVERR);
      wr(8'h14, 32'hff, RESP_SLVERR);
      `CHK(wdt_enable, 1'b1)
      `CHK(mode, SINGLE_CLOCK_FAST_MODE)
   endtask
   task automatic s_slow_switch();
      logic prev;
      wr(OFF_SYS_CTRL, 32'hc0, RESP_OKAY);
      `CHK(lo_osc_run, 1'b1)
      wr(OFF_SYS_CTRL, 32'he0, RESP_OKAY);
      repeat (3) @(negedge ref_clk);
      `CHK(run_on_lo, 1'b1)
      `CHK(mode, LOW_CLOCK_DUAL_OSC_MODE)
      wr(OFF_SYS_CTRL, 32'h60, RESP_OKAY);
      `CHK(hi_osc_run, 1'b0)
      `CHK(mode, LOW_CLOCK_ONLY_MODE)
      wr(OFF_SYS_CTRL, 32'he0, RESP_OKAY);
      // changeover must land just after a low clock tick
      fork
         wr(OFF_SYS_CTRL, 32'hc0, RESP_OKAY);
         begin
            prev = 1'b0;
            for (int n = 0; n < 60 && run_on_lo !== 1'b0; n++) begin
               prev = lo_tick;
               @(negedge ref_clk);
            end
         end
      join
      `CHK(prev, 1'b1)
      `CHK(mode, DUAL_CLOCK_FAST_MODE)
   endtask
   task automatic s_clock_loss();
      logic [7:0] bad [3] = '{8'h00, 8'h40, 8'ha0};
      for (int i = 0; i < 3; i++) begin
         fork
            wr(OFF_SYS_CTRL, {24'h0, bad[i]}, RESP_OKAY);
            rst_len(len);
         join
         `CHK(len, INT_RST_CYC)
         rdc(OFF_SYS_CTRL, 32'hff, SYS_CTRL_RST, RESP_OKAY);
         rdc(OFF_STATUS, 32'hf0, 32'h10, RESP_OKAY);
      end
   endtask
   task automatic s_trap(input logic [7:0] ctrl, input logic [15:0] a, input int exp_len);
      wr(OFF_TRAP_CTRL, {24'h0, ctrl}, RESP_OKAY);
      fork
         cpu.fetch(a);
         rst_len(len);
      join
      `CHK(len, exp_len)
   endtask
   task automatic s_wdt();
      cpu.request(1'b0, 16'h0010);
      rdc(OFF_IRQ_LATCH, 32'hffff, 32'h0014, RESP_OKAY);
      wr(OFF_IRQ_EN, 32'h0005, RESP_OKAY);
      @(negedge ref_clk);
      `CHK(irq_pending, 1'b1)
      wr(OFF_IRQ_EN, 32'hffff, RESP_OKAY);
      fork
         cpu.request(1'b1, 16'h0000);
         rst_len(len);
      join
      `CHK(len, INT_RST_CYC)
      rdc(OFF_IRQ_EN, 32'hffff, IRQ_RST, RESP_OKAY);
      rdc(OFF_IRQ_LATCH, 32'hffff, IRQ_RST, RESP_OKAY);
      rdc(OFF_STATUS, 32'hf0, 32'h20, RESP_OKAY);
      `CHK(wdt_enable, 1'b1)
   endtask
   task automatic s_pin_reset();
      wr(OFF_SYS_CTRL, 32'hc0, RESP_OKAY);
      wr(OFF_SYS_CTRL, 32'he0, RESP_OKAY);
      fork
         cpu.pin_low(PIN_LOW_CYC - 1);
         rst_len(len);
      join
      `CHK(len, 0)
      fork
         cpu.pin_low(PIN_LOW_CYC);
         rst_len(len);
      join
      `CHK(len > 0, 1'b1)
      `CHK(mode, SINGLE_CLOCK_FAST_MODE)
      rdc(OFF_STATUS, 32'hf0, 32'h80, RESP_OKAY);
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      s_reset_values();
      s_slow_switch();
      s_clock_loss();
      s_trap(8'h07, 16'h0050, INT_RST_CYC);
      rdc(OFF_TRAP_CTRL, 32'hff, TRAP_CTRL_RST, RESP_OKAY);
      s_trap(8'h06, 16'h0050, 0);
      s_trap(8'h06, 16'h0f10, INT_RST_CYC);
      s_trap(8'h04, 16'h0020, 0);
      s_wdt();
      s_pin_reset();
      print_verdict();
   end
endmodule
`default_nettype wire
